/* tb/conv_props.sv */
// assertions on the converter register link
`timescale 1ns/1ps
module conv_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // link
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic done,
    input wire logic ref_oe_n
);
default clocking @(posedge CLK); endclocking
default disable iff (!RESETN);
logic [15:0] ctrl;
logic [7:0] en;
logic [15:0] since;
logic [15:0] res;
logic have;
logic rd_q;
wire start = wr && addr == conv_pkg::OFF_CTRL && wdata[0];
wire rd_res = rd && addr == conv_pkg::OFF_RESULT;
wire rd_ctl = rd && addr == conv_pkg::OFF_CTRL;
always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
        ctrl <= 16'h0000;
        en <= 8'h00;
        since <= 16'h0000;
        res <= 16'h0000;
        have <= 1'b0;
        rd_q <= 1'b0;
    end else begin
        rd_q <= rd_res;
        if (wr && addr == conv_pkg::OFF_CTRL) ctrl <= wdata;
        if (wr && addr == conv_pkg::OFF_PIN_EN) en <= wdata[7:0];
        since <= start ? 16'h0000 : since + {15'h0000, since != 16'hffff};
        if (done || start) have <= 1'b0;
        else if (rd_q) have <= 1'b1;
        if (rd_q) res <= rdata;
    end
end
a_pin_input_read: assert property (
    rd && addr == conv_pkg::OFF_PIN_IN |=> (rdata & ~{8'h00, en}) == 16'h0000
) else $error("pin input read shows disabled or high bits");
a_enable_readback: assert property (
    rd && addr == conv_pkg::OFF_PIN_EN |=> rdata == {8'h00, en}
) else $error("enable register read differs from last write");
a_start_clears: assert property (
    rd_ctl |=> rdata[0] == 1'b0 && rdata[15] == 1'b0
) else $error("start bit reads back set");
a_ctrl_readback: assert property (
    rd_ctl |=> rdata[14:1] == ctrl[14:1]
) else $error("control read differs from last write");
a_rsvd_zero: assert property (
    rd && addr == conv_pkg::OFF_RSVD |=> rdata == 16'h0000
) else $error("reserved slot reads nonzero");
a_ref_pin: assert property (
    ref_oe_n == !(ctrl[1] && !ctrl[12])
) else $error("reference pin drive disagrees with control");
a_done_pulse: assert property (
    done |=> !done
) else $error("completion longer than one cycle");
a_sample_window: assert property (
    done |-> since >= 16'h001a
) else $error("conversion finished too early");
a_result_hold: assert property (
    rd_res && have && !done |=> rdata == res && rdata[15:14] == 2'b00
) else $error("result changed without a conversion");
endmodule

/* tb/tb.sv */
// self-checking bench for the converter control pair
`timescale 1ns/1ps
module tb;
logic clk = 1'b0;
logic resetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] prdata;
logic pready;
logic [7:0] pin_level = 8'h00;
logic [13:0] core_code = 14'h0000;
logic [7:0] digital_en;
logic [2:0] channel;
logic channel_on, source_on, auto_range, comparator_on, result_valid;
logic [1:0] source_pin, range;
logic sampling;
int checks = 0, n_fail = 0, cyc = 0, t_start = 0, t_conv = 0, lo = 0;
int n_samp = 0, sp = 0;
logic [31:0] rnd = 32'h0000_dc3f;
logic [15:0] r;
logic [14:0] c;
logic [15:0] e;
conv_if link();
always #5 clk = ~clk;
conv_device i_conv_device (.CLK(clk), .RESETN(resetn), .BUS(link),
    .PIN_LEVEL(pin_level), .CORE_CODE(core_code), .DIGITAL_EN(digital_en),
    .CHANNEL(channel), .CHANNEL_ON(channel_on), .SOURCE_PIN(source_pin),
    .SOURCE_ON(source_on), .RANGE(range), .AUTO_RANGE(auto_range),
    .COMPARATOR_ON(comparator_on), .SAMPLING(sampling),
    .RESULT_VALID(result_valid));
conv_host i_conv_host (.CLK(clk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .DEV(link));
conv_props i_conv_props (.CLK(clk), .RESETN(resetn), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .wr(link.wr), .rd(link.rd),
    .done(link.done), .ref_oe_n(link.ref_oe_n));
////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function automatic logic [15:0] ctrl_rd(input logic [14:0] v);
    return {1'b0, v[14:1], 1'b0};
endfunction
function automatic logic [15:0] exp_result(input logic auto_on,
    input logic [13:0] v);
    return auto_on ? {2'b00, v} : {4'h0, v[11:0]};
endfunction
task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
        n_fail++;
        $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rv);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic dev(input logic w, input logic [15:0] a, input logic [14:0] d,
    output logic [15:0] rv);
    logic [31:0] v;
    int n;
    apb(1'b1, conv_pkg::APB_CMD, {w, d, a}, v);
    n = 0;
    do begin
        apb(1'b0, conv_pkg::APB_STATUS, 32'h0000_0000, v);
        n++;
    end while (v[0] !== 1'b0 && n < 20);
    check("host idle", v[0], 1'b0);
    apb(1'b0, conv_pkg::APB_RDATA, 32'h0000_0000, v);
    rv = v[15:0];
endtask
task automatic wait_done();
    logic [31:0] v;
    int n;
    n = 0;
    do begin
        apb(1'b0, conv_pkg::APB_STATUS, 32'h0000_0000, v);
        n++;
    end while (v[1] !== 1'b1 && n < 100);
    check("done seen", v[1], 1'b1);
endtask
////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sampling) n_samp <= n_samp + 1;
    if (link.wr && link.addr == conv_pkg::OFF_CTRL && link.wdata[0]) begin
        t_start <= cyc;
        n_samp <= 0;
    end
    if (link.done) t_conv <= cyc - t_start;
    if (cyc == 20000) begin
        n_fail++;
        stop_test();
    end
end
initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
        dev(1'b0, 16'h0110 + 16'(2 * i), 15'h0000, r);
        check("reset value", r, 32'h0000_0000);
    end
    for (int i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        pin_level <= rnd[7:0];
        dev(1'b1, conv_pkg::OFF_PIN_EN, {7'h00, rnd[15:8]}, r);
        dev(1'b1, conv_pkg::OFF_PIN_IN, rnd[30:16], r);
        dev(1'b1, conv_pkg::OFF_RSVD, rnd[30:16], r);
        dev(1'b0, conv_pkg::OFF_PIN_IN, 15'h0000, r);
        check("pin in", r, {8'h00, rnd[7:0] & rnd[15:8]});
        dev(1'b0, conv_pkg::OFF_PIN_EN, 15'h0000, r);
        check("pin enable", r, {8'h00, rnd[15:8]});
        check("enable out", digital_en, rnd[15:8]);
        dev(1'b0, conv_pkg::OFF_RSVD, 15'h0000, r);
        check("reserved", r, 32'h0000_0000);
    end
    for (int k = 0; k < 8; k++) begin
        rnd = lfsr(rnd);
        core_code <= rnd[31:18];
        c = {k[1:0], 1'b0, k[2], rnd[10:1], 1'b1};
        lo = (conv_pkg::SAMPLE_CLKS + conv_pkg::CONV_CLKS - 1) * (k % 4 + 1);
        sp = conv_pkg::SAMPLE_CLKS * (k % 4 + 1);
        dev(1'b1, conv_pkg::OFF_CTRL, c, r);
        check("channel", {channel_on, channel}, {!c[5], c[4:2]});
        check("source", {source_on, source_pin}, {!c[8], c[7:6]});
        check("range", {auto_range, range},
            {c[11], c[11] ? 2'b00 : c[10:9]});
        check("reference", {link.ref_oe_n, link.ref_out},
            {!c[1], c[1]});
        dev(1'b0, conv_pkg::OFF_CTRL, 15'h0000, r);
        check("control", r, ctrl_rd(c));
        wait_done();
        check("conv time", t_conv > lo && t_conv <= lo + k % 4 + 3,
            1);
        check("sample time", n_samp > sp - k % 4 - 1 && n_samp <= sp,
            1);
        e = exp_result(c[11], core_code);
        dev(1'b0, conv_pkg::OFF_RESULT, 15'h0000, r);
        check("result", r, e);
        check("valid", result_valid, 1'b1);
        core_code <= ~core_code;
        dev(1'b0, conv_pkg::OFF_RESULT, 15'h0000, r);
        check("result hold", r, e);
    end
    dev(1'b1, conv_pkg::OFF_CTRL, 15'h0001, r);
    dev(1'b1, conv_pkg::OFF_CTRL, 15'h0004, r);
    wait_done();
    check("changed valid", result_valid, 1'b0);
    dev(1'b1, conv_pkg::OFF_CTRL, 15'h1002, r);
    check("power down", {comparator_on, source_on, link.ref_oe_n,
        link.ref_out}, 4'b0010);
    dev(1'b1, conv_pkg::OFF_CTRL, 15'h0002, r);
    check("power up", {comparator_on, link.ref_oe_n, link.ref_out},
        3'b101);
    repeat (conv_pkg::STABLE_CYCLES) @(posedge clk);
    dev(1'b1, conv_pkg::OFF_CTRL, 15'h0003, r);
    wait_done();
    check("valid after wake", result_valid, 1'b1);
    stop_test();
end
endmodule

/* verilog/clk_div.sv */
// converter clock tick generator, divide by 1 to 4
`timescale 1ns/1ps
module clk_div (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // control
    input wire logic [1:0] DIV,
    input wire logic CLEAR,
    // tick
    output logic TICK
);
    typedef struct packed {
        logic [1:0] cnt;
    } div_t;
    div_t s;
    div_t next_s;

    always_comb begin
        next_s = s;
        if (CLEAR || s.cnt >= DIV) begin
            next_s.cnt = 2'h0;
        end else begin
            next_s.cnt = s.cnt + 2'h1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign TICK = !CLEAR && (s.cnt >= DIV); // RULE18
endmodule

/* verilog/conv_device.sv */
// converter control registers and conversion sequencer
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Functional notes
// (RULE1) pin input register read-only, high byte zero
// (RULE2) bits 0 to 7 map to A0 to A7
// (RULE3) input bit is pin AND enable
// (RULE4) enable register low byte, high reads zero
// (RULE5) enable 1 digital, 0 analog reads zero
// (RULE6) enables cleared at reset
// (RULE7) result held until next start
// (RULE8) start bit self-clears
// (RULE9) reference switch drives reference pin out
// (RULE10) bits 2-5 select channel, bit5 none
// (RULE11) bits 6-8 select source, bit8 none
// (RULE12) selection change mid-conversion invalidates result
// (RULE13) bits 10:9 select range A-D
// (RULE14) software keeps range bits during conversion
// (RULE15) bit 11 selects auto-range 14-bit mode
// (RULE16) power-down opens switch, stops comparator, source
// (RULE17) software waits 6 us after power-up
// (RULE18) bits 14:13 divide clock by 1-4
// (RULE19) result limited to 0FFFh or 3FFFh
// (RULE20) sample window twelve converter clocks
// (RULE21) completion pulse with result update
module conv_device (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // bus side
    conv_if.device BUS,
    // analog front end
    input wire logic [7:0] PIN_LEVEL,
    input wire logic [13:0] CORE_CODE,
    output logic [7:0] DIGITAL_EN,
    output logic [2:0] CHANNEL,
    output logic CHANNEL_ON,
    output logic [1:0] SOURCE_PIN,
    output logic SOURCE_ON,
    output logic [1:0] RANGE,
    output logic AUTO_RANGE,
    output logic COMPARATOR_ON,
    output logic SAMPLING,
    output logic RESULT_VALID
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } phase_t;
    typedef struct packed {
        logic [7:0] pin_en;
        logic [15:0] ctrl;
        logic [15:0] result;
        logic [15:0] rdata;
        logic [4:0] tick_cnt;
        phase_t phase;
        logic [6:0] sel_snap;
        logic [2:0] rng_snap;
        logic invalid;
        logic valid;
        logic done;
    } dev_t;
    dev_t s;
    dev_t next_s;
    logic tick;
    logic [7:0] pin_in;
    logic [15:0] code;
    logic busy;
    logic ref_drive;

    ////////////////////////////////////////////////////////////////////
    // divider free-runs, so the first tick may lag a start
    clk_div u_div (
        .CLK(CLK),
        .RESETN(RESETN),
        .DIV(s.ctrl[conv_pkg::B_DIV_LO +: 2]), // RULE18
        .CLEAR(s.ctrl[conv_pkg::B_PD]),
        .TICK(tick)
    );

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign pin_in[g] = PIN_LEVEL[g] & s.pin_en[g]; // RULE2 RULE3 RULE5
        end
    endgenerate

    // core code trimmed to the span of the mode
    always_comb begin
        if (s.ctrl[conv_pkg::B_AUTO]) begin // RULE15
            code = {2'b00, CORE_CODE} & conv_pkg::MAX_14BIT; // RULE19
        end else begin
            code = {4'h0, CORE_CODE[11:0]} & conv_pkg::MAX_12BIT; // RULE19
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.ctrl[conv_pkg::B_SOC] = 1'b0; // RULE8
        // read data stands until the next read
        if (BUS.rd) begin
            case (BUS.addr)
                conv_pkg::OFF_PIN_IN: next_s.rdata = {8'h00, pin_in}; // RULE1
                conv_pkg::OFF_PIN_EN:
                    next_s.rdata = {8'h00, s.pin_en}; // RULE4
                conv_pkg::OFF_CTRL: next_s.rdata = s.ctrl;
                conv_pkg::OFF_RESULT: next_s.rdata = s.result;
                default: next_s.rdata = 16'h0000;
            endcase
        end
        if (BUS.wr) begin
            case (BUS.addr)
                conv_pkg::OFF_PIN_EN: next_s.pin_en = BUS.wdata[7:0]; // RULE4
                conv_pkg::OFF_CTRL: next_s.ctrl = {1'b0, BUS.wdata[14:0]};
                default: ;
            endcase
        end
        // a write selecting other pins while busy spoils the result
        if (s.phase != ST_IDLE &&
            next_s.ctrl[8:2] != s.sel_snap) begin
            next_s.invalid = 1'b1; // RULE12
        end
        // a start pulse seen while busy is dropped
        case (s.phase)
            ST_IDLE: begin
                if (s.ctrl[conv_pkg::B_SOC] && !s.ctrl[conv_pkg::B_PD]) begin
                    next_s.phase = ST_SAMPLE;
                    next_s.tick_cnt = 5'h00;
                    next_s.sel_snap = s.ctrl[8:2];
                    next_s.rng_snap = s.ctrl[11:9];
                    next_s.invalid = 1'b0;
                    next_s.valid = 1'b0; // RULE7
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    if (s.tick_cnt == 5'(conv_pkg::SAMPLE_CLKS - 1)) begin
                        next_s.phase = ST_CONVERT; // RULE20
                        next_s.tick_cnt = 5'h00;
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 5'h01;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (s.tick_cnt == 5'(conv_pkg::CONV_CLKS - 1)) begin
                        next_s.phase = ST_IDLE;
                        next_s.result = code; // RULE7 RULE21
                        next_s.done = 1'b1; // RULE21
                        next_s.valid = !next_s.invalid;
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 5'h01;
                    end
                end
            end
            default: next_s.phase = ST_IDLE;
        endcase
        // power-down aborts any conversion
        if (s.ctrl[conv_pkg::B_PD] && busy) begin
            next_s.phase = ST_IDLE;
            next_s.valid = 1'b0;
        end
    end

    // reset leaves every pin analog and the sequencer idle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s.pin_en <= conv_pkg::PIN_EN_RESET; // RULE6
            s.ctrl <= conv_pkg::CTRL_RESET;
            s.result <= conv_pkg::RESULT_RESET;
            s.rdata <= 16'h0000;
            s.tick_cnt <= 5'h00;
            s.phase <= ST_IDLE;
            s.sel_snap <= 7'h00;
            s.rng_snap <= 3'h0;
            s.invalid <= 1'b0;
            s.valid <= 1'b0;
            s.done <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic pd;
    assign pd = s.ctrl[conv_pkg::B_PD];
    assign busy = (s.phase != ST_IDLE);
    assign ref_drive = s.ctrl[conv_pkg::B_REFSW] && !pd; // RULE9 RULE16
    assign BUS.rdata = s.rdata;
    assign BUS.done = s.done;
    assign BUS.ref_out = ref_drive; // RULE9 RULE16
    assign BUS.ref_oe_n = !ref_drive; // RULE9
    assign DIGITAL_EN = s.pin_en; // RULE5
    assign CHANNEL = s.ctrl[conv_pkg::B_CH_LO +: 3]; // RULE10
    assign CHANNEL_ON = !s.ctrl[conv_pkg::B_CH_NONE]; // RULE10
    assign SOURCE_PIN = s.ctrl[conv_pkg::B_CS_LO +: 2]; // RULE11
    assign SOURCE_ON = !s.ctrl[conv_pkg::B_CS_NONE] && !pd; // RULE11 RULE16
    // range used is the one latched at start; auto ignores it
    assign RANGE = s.rng_snap[2] ? 2'b00 : s.rng_snap[1:0]; // RULE13 RULE15
    assign AUTO_RANGE = s.rng_snap[2]; // RULE15
    assign COMPARATOR_ON = !pd; // RULE16
    assign SAMPLING = (s.phase == ST_SAMPLE);
    assign RESULT_VALID = s.valid;
endmodule

/* verilog/conv_host.sv */
// APB-facing controller that drives the converter register bus
`timescale 1ns/1ps
module conv_host (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // converter side
    conv_if.host DEV
);
    typedef enum logic [1:0] {
        H_IDLE,
        H_ISSUE,
        H_WAIT
    } hstate_t;
    typedef struct packed {
        hstate_t st;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic busy;
        logic done_seen;
    } host_t;
    host_t s;
    host_t next_s;
    logic acc;
    assign acc = PSEL && PENABLE;

    always_comb begin
        next_s = s;
        if (DEV.done) begin
            next_s.done_seen = 1'b1;
        end else if (acc && !PWRITE && PADDR == conv_pkg::APB_STATUS) begin
            next_s.done_seen = 1'b0;
        end
        case (s.st)
            H_IDLE: begin
                if (acc && PWRITE && PADDR == conv_pkg::APB_CMD) begin
                    next_s.addr = PWDATA[15:0];
                    next_s.wdata = PWDATA[31:16];
                    next_s.st = H_ISSUE;
                    next_s.busy = 1'b1;
                end
            end
            H_ISSUE: begin
                next_s.st = H_WAIT;
            end
            H_WAIT: begin
                next_s.rdata = DEV.rdata;
                next_s.st = H_IDLE;
                next_s.busy = 1'b0;
            end
            default: next_s.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // command word: addr[15:0], data[30:16], bit 31 selects write
    logic cmd_wr;
    assign cmd_wr = s.wdata[15];
    assign DEV.addr = s.addr;
    assign DEV.wdata = {1'b0, s.wdata[14:0]};
    assign DEV.wr = (s.st == H_ISSUE) && cmd_wr;
    assign DEV.rd = (s.st == H_ISSUE) && !cmd_wr;
    // never drive the reference while the device drives it
    assign DEV.ref_in = 1'b0; // RULE9
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    always_comb begin
        case (PADDR)
            conv_pkg::APB_STATUS: PRDATA = {30'h0, s.done_seen, s.busy};
            conv_pkg::APB_RDATA: PRDATA = {16'h0000, s.rdata};
            default: PRDATA = 32'h0000_0000;
        endcase
    end
endmodule

/* verilog/conv_if.sv */
// link between the converter control block and its bus controller
`timescale 1ns/1ps
interface conv_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic done;
    logic ref_in;
    logic ref_out;
    logic ref_oe_n;
    modport device (
        input addr, wdata, wr, rd, ref_in,
        output rdata, done, ref_out, ref_oe_n
    );
    modport host (
        output addr, wdata, wr, rd, ref_in,
        input rdata, done, ref_out, ref_oe_n
    );
endinterface

/* verilog/conv_pkg.sv */
// shared constants and types for the converter control block
package conv_pkg;
    // register offsets on the memory data bus
    localparam logic [15:0] OFF_PIN_IN = 16'h0110;
    localparam logic [15:0] OFF_PIN_EN = 16'h0112;
    localparam logic [15:0] OFF_CTRL = 16'h0114;
    localparam logic [15:0] OFF_RSVD = 16'h0116;
    localparam logic [15:0] OFF_RESULT = 16'h0118;
    // control word fields
    localparam int B_SOC = 0;
    localparam int B_REFSW = 1;
    localparam int B_CH_LO = 2;
    localparam int B_CH_NONE = 5;
    localparam int B_CS_LO = 6;
    localparam int B_CS_NONE = 8;
    localparam int B_RANGE_LO = 9;
    localparam int B_AUTO = 11;
    localparam int B_PD = 12;
    localparam int B_DIV_LO = 13;
    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] PIN_EN_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // result spans
    localparam logic [15:0] MAX_12BIT = 16'h0FFF;
    localparam logic [15:0] MAX_14BIT = 16'h3FFF;
    // timing
    localparam int SAMPLE_CLKS = 12;
    localparam int CONV_CLKS = 14;
    localparam int STABLE_US = 6;
    localparam int CLK_MHZ = 100;
    localparam int STABLE_CYCLES = STABLE_US * CLK_MHZ;
    // APB register map of the controller
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_RDATA = 8'h08;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE
    } op_t;
endpackage
